// ### rtl/wbc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - neutral samples join a burst read only while neutral readout is on.
// - the source field picks the stored stream and the ready strobe rate.
// - source 00 stores raw sinc4 output at 16 kSPS.
// - source 01 is reserved, 10 stores low-passed sinc4 at 4 kSPS.
// - source 11 stores fully processed current and voltage samples at 4 kSPS.
// - the fill mode sets how fixed rate captures fill and meet triggers.
// - fill mode 00 fills once and stops writing when the buffer is full.
// - fill mode 01 wraps continuously and stops on an enabled trigger.
// - fill mode 10 wraps and on a trigger stops with it in the middle.
// - fill mode 11 never stops and records the address of each trigger.
// - capture type 0 stores resampled data and 1 stores fixed rate data.
// - a capture starts only on a rising edge of the capture go bit.
// - while capture go is 0 nothing is written and contents stay intact.
// - burst code 0000 reads all six phase channels plus the enabled neutral, 0001 to 0011 phase a, b, c pairs.
// - codes 1000 to 1101 read one channel each, 1110 the enabled neutral.
// - burst code 1111 disables bursts so each read returns one word.
module wbc_ctrl #(
   parameter int DEPTH = 2048
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic sinc4_strobe_in,
   input wire logic filtered_strobe_in,
   input wire logic processed_strobe_in,
   input wire logic resample_strobe_in,
   input wire logic trigger_in,
   output logic sample_ready_strobe_out,
   output logic buf_wr_en_out,
   output logic [$clog2(DEPTH)-1:0] buf_wr_addr_out,
   output logic [$clog2(DEPTH)-1:0] trig_addr_out,
   output logic capture_active_out,
   output logic capture_done_out,
   output logic burst_enable_out,
   output logic [6:0] burst_mask_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
   localparam logic [AW-1:0] HALF = AW'(DEPTH / 2);
   localparam logic [AW-1:0] POST_ONE = AW'(1);

   logic [15:0] cfg_r, cfg_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic go_prev_r;
   logic ready_r, ready_nxt;
   wbc_pkg::wbc_state_e st_r, st_nxt;
   logic [AW-1:0] waddr_r, waddr_nxt;
   logic [AW-1:0] last_r, last_nxt;
   logic [AW-1:0] taddr_r, taddr_nxt;
   logic [AW-1:0] post_r, post_nxt;
   logic wr_r, wr_nxt;
   logic act_r, act_nxt;
   logic done_r, done_nxt;
   logic ben_r, ben_nxt;
   logic [6:0] mask_r, mask_nxt;

   logic [1:0] src;
   logic [1:0] mode;
   logic [3:0] bsel;
   logic go, rise, fixed, once, src_strobe, smp;

   assign src = cfg_r[wbc_pkg::SRC_LSB +: 2];
   assign mode = cfg_r[wbc_pkg::MODE_LSB +: 2];
   assign bsel = cfg_r[wbc_pkg::BURST_LSB +: 4];
   assign go = cfg_r[wbc_pkg::GO_BIT];
   assign rise = go && !go_prev_r;
   assign fixed = (cfg_r[wbc_pkg::TYPE_BIT] == wbc_pkg::TYPE_FIXED);
   // resampled captures have no trigger modes, so they fill once
   assign once = !fixed || (mode == wbc_pkg::MODE_ONCE);

   always_comb begin
      src_strobe = 1'b0;
      case (src)
         wbc_pkg::SRC_SINC4: src_strobe = sinc4_strobe_in;
         wbc_pkg::SRC_IIR: src_strobe = filtered_strobe_in;
         wbc_pkg::SRC_DSP: src_strobe = processed_strobe_in;
         default: src_strobe = 1'b0; // reserved code never strobes
      endcase
   end
   assign smp = fixed ? src_strobe : resample_strobe_in;

   always_comb begin
      cfg_nxt = cfg_r;
      rdata_nxt = 16'h0000;
      rvalid_nxt = reg_rd_in;
      if (reg_wr_in && reg_addr_in == wbc_pkg::CFG_ADDR) begin
         cfg_nxt = reg_wdata_in & wbc_pkg::CFG_WMASK;
      end
      if (reg_rd_in && reg_addr_in == wbc_pkg::CFG_ADDR) begin
         rdata_nxt = cfg_r;
      end
      ready_nxt = src_strobe;
   end

   always_comb begin
      st_nxt = st_r;
      waddr_nxt = waddr_r;
      last_nxt = last_r;
      taddr_nxt = taddr_r;
      post_nxt = post_r;
      wr_nxt = 1'b0;
      if (!go) begin
         st_nxt = wbc_pkg::WBC_IDLE;
      end else if (rise) begin
         st_nxt = wbc_pkg::WBC_FILL;
         waddr_nxt = '0;
      end else begin
         case (st_r)
            wbc_pkg::WBC_FILL: begin
               if (smp) begin
                  wr_nxt = 1'b1;
                  last_nxt = waddr_r;
                  waddr_nxt = waddr_r + POST_ONE;
                  if (once && waddr_r == LAST_ADDR) begin
                     st_nxt = wbc_pkg::WBC_DONE;
                  end
               end
               if (trigger_in && !once) begin
                  taddr_nxt = smp ? waddr_r : last_r;
                  if (mode == wbc_pkg::MODE_STOP_TRIG) begin
                     st_nxt = wbc_pkg::WBC_DONE;
                  end else if (mode == wbc_pkg::MODE_CENTER) begin
                     st_nxt = wbc_pkg::WBC_POST;
                     post_nxt = HALF;
                  end
               end
            end
            wbc_pkg::WBC_POST: begin
               // half a buffer after the trigger leaves it centred
               if (smp) begin
                  wr_nxt = 1'b1;
                  last_nxt = waddr_r;
                  waddr_nxt = waddr_r + POST_ONE;
                  post_nxt = post_r - POST_ONE;
                  if (post_r == POST_ONE) begin
                     st_nxt = wbc_pkg::WBC_DONE;
                  end
               end
            end
            default: st_nxt = st_r;
         endcase
      end
      act_nxt = (st_nxt == wbc_pkg::WBC_FILL) ||
                (st_nxt == wbc_pkg::WBC_POST);
      done_nxt = (st_nxt == wbc_pkg::WBC_DONE);
   end

   always_comb begin
      ben_nxt = 1'b1;
      mask_nxt = wbc_pkg::MASK_NONE;
      if (bsel == wbc_pkg::BURST_ALL) begin
         mask_nxt = wbc_pkg::MASK_PHASES;
         mask_nxt[wbc_pkg::CH_IN] = cfg_r[wbc_pkg::NEUT_BIT];
      end else if (bsel == wbc_pkg::BURST_A) begin
         mask_nxt = wbc_pkg::MASK_A;
      end else if (bsel == wbc_pkg::BURST_B) begin
         mask_nxt = wbc_pkg::MASK_B;
      end else if (bsel == wbc_pkg::BURST_C) begin
         mask_nxt = wbc_pkg::MASK_C;
      end else if (bsel >= wbc_pkg::BURST_SINGLE_LO &&
                   bsel <= wbc_pkg::BURST_SINGLE_HI) begin
         mask_nxt = wbc_pkg::MASK_ONE << bsel[2:0];
      end else if (bsel == wbc_pkg::BURST_NEUT) begin
         mask_nxt = cfg_r[wbc_pkg::NEUT_BIT] ? wbc_pkg::MASK_NEUT
                                             : wbc_pkg::MASK_NONE;
      end else begin
         ben_nxt = 1'b0; // undefined codes also read single words
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cfg_r <= wbc_pkg::CFG_RESET;
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         go_prev_r <= 1'b0;
         ready_r <= 1'b0;
         st_r <= wbc_pkg::WBC_IDLE;
         waddr_r <= '0;
         last_r <= '0;
         taddr_r <= '0;
         post_r <= '0;
         wr_r <= 1'b0;
         act_r <= 1'b0;
         done_r <= 1'b0;
         ben_r <= 1'b0;
         mask_r <= wbc_pkg::MASK_NONE;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         go_prev_r <= go;
         ready_r <= ready_nxt;
         st_r <= st_nxt;
         waddr_r <= waddr_nxt;
         last_r <= last_nxt;
         taddr_r <= taddr_nxt;
         post_r <= post_nxt;
         wr_r <= wr_nxt;
         act_r <= act_nxt;
         done_r <= done_nxt;
         ben_r <= ben_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign reg_rvalid_out = rvalid_r;
   assign sample_ready_strobe_out = ready_r;
   assign buf_wr_en_out = wr_r;
   assign buf_wr_addr_out = last_r;
   assign trig_addr_out = taddr_r;
   assign capture_active_out = act_r;
   assign capture_done_out = done_r;
   assign burst_enable_out = ben_r;
   assign burst_mask_out = mask_r;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_neut;
      burst_mask_out[wbc_pkg::CH_IN] |-> $past(cfg_r[wbc_pkg::NEUT_BIT]);
   endproperty
   a_neut: assert property (p_neut) else $error("stray neutral");
   property p_sinc4;
      (src == wbc_pkg::SRC_SINC4 && sinc4_strobe_in) |=> ready_r;
   endproperty
   a_sinc4: assert property (p_sinc4) else $error("sinc4 ready lost");
   property p_iir;
      (src == wbc_pkg::SRC_IIR && filtered_strobe_in) |=> ready_r;
   endproperty
   a_iir: assert property (p_iir) else $error("filtered ready lost");
   property p_dsp;
      (src == wbc_pkg::SRC_DSP && processed_strobe_in) |=> ready_r;
   endproperty
   a_dsp: assert property (p_dsp) else $error("processed ready lost");
   property p_once;
      (go && !rise && st_r == wbc_pkg::WBC_FILL && once && smp &&
       waddr_r == LAST_ADDR) |=> capture_done_out ##1 !buf_wr_en_out;
   endproperty
   a_once: assert property (p_once) else $error("wrote past full");
   property p_stop;
      (go && !rise && st_r == wbc_pkg::WBC_FILL && fixed && trigger_in &&
       mode == wbc_pkg::MODE_STOP_TRIG) |=> st_r == wbc_pkg::WBC_DONE;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop on trigger");
   property p_center;
      (go && !rise && st_r == wbc_pkg::WBC_FILL && fixed && trigger_in &&
       mode == wbc_pkg::MODE_CENTER) |=> post_r == HALF && capture_active_out;
   endproperty
   a_center: assert property (p_center) else $error("bad post count");
   property p_mark;
      (go && !rise && st_r == wbc_pkg::WBC_FILL && fixed && trigger_in &&
       smp && mode == wbc_pkg::MODE_MARK)
         |=> st_r == wbc_pkg::WBC_FILL && trig_addr_out == $past(waddr_r);
   endproperty
   a_mark: assert property (p_mark) else $error("trigger mark wrong");
   property p_start;
      rise |=> st_r == wbc_pkg::WBC_FILL && waddr_r == '0;
   endproperty
   a_start: assert property (p_start) else $error("no capture start");
   property p_hold;
      !go |=> !buf_wr_en_out ##1 !buf_wr_en_out;
   endproperty
   a_hold: assert property (p_hold) else $error("write while idle");
   property p_pair_a;
      bsel == wbc_pkg::BURST_A |=> burst_mask_out == wbc_pkg::MASK_A;
   endproperty
   a_pair_a: assert property (p_pair_a) else $error("pair a wrong");
   property p_off;
      bsel == wbc_pkg::BURST_OFF |=> !burst_enable_out;
   endproperty
   a_off: assert property (p_off) else $error("burst not disabled");
   property p_rsv_bits;
      reg_rvalid_out |-> (reg_rdata_out & ~wbc_pkg::CFG_WMASK) == 16'h0000;
   endproperty
   a_rsv_bits: assert property (p_rsv_bits) else $error("stray bits");

   c_full: cover property (capture_done_out && once);
   c_center: cover property (st_r == wbc_pkg::WBC_POST ##1
                             st_r == wbc_pkg::WBC_DONE);
   c_mark: cover property (fixed && mode == wbc_pkg::MODE_MARK && trigger_in);
endmodule
`default_nettype wire

// ### rtl/wbc_pkg.sv
`default_nettype none
package wbc_pkg;
   localparam logic [11:0] CFG_ADDR = 12'h4a0;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'h13ff;
   localparam int NEUT_BIT = 12;
   localparam int SRC_LSB = 8;
   localparam int MODE_LSB = 6;
   localparam int TYPE_BIT = 5;
   localparam int GO_BIT = 4;
   localparam int BURST_LSB = 0;
   localparam logic [1:0] SRC_SINC4 = 2'h0;
   localparam logic [1:0] SRC_RSVD = 2'h1;
   localparam logic [1:0] SRC_IIR = 2'h2;
   localparam logic [1:0] SRC_DSP = 2'h3;
   localparam int SINC4_KSPS = 16;
   localparam int FILTERED_KSPS = 4;
   localparam logic [1:0] MODE_ONCE = 2'h0;
   localparam logic [1:0] MODE_STOP_TRIG = 2'h1;
   localparam logic [1:0] MODE_CENTER = 2'h2;
   localparam logic [1:0] MODE_MARK = 2'h3;
   localparam logic TYPE_RESAMPLED = 1'h0;
   localparam logic TYPE_FIXED = 1'h1;
   localparam logic [3:0] BURST_ALL = 4'h0;
   localparam logic [3:0] BURST_A = 4'h1;
   localparam logic [3:0] BURST_B = 4'h2;
   localparam logic [3:0] BURST_C = 4'h3;
   localparam logic [3:0] BURST_SINGLE_LO = 4'h8;
   localparam logic [3:0] BURST_SINGLE_HI = 4'hd;
   localparam logic [3:0] BURST_NEUT = 4'he;
   localparam logic [3:0] BURST_OFF = 4'hf;
   // channel mask bit order: ia va ib vb ic vc in
   localparam int CH_IN = 6;
   localparam logic [6:0] MASK_NONE = 7'h00;
   localparam logic [6:0] MASK_ONE = 7'h01;
   localparam logic [6:0] MASK_PHASES = 7'h3f;
   localparam logic [6:0] MASK_A = 7'h03;
   localparam logic [6:0] MASK_B = 7'h0c;
   localparam logic [6:0] MASK_C = 7'h30;
   localparam logic [6:0] MASK_NEUT = 7'h40;
   typedef enum logic [1:0] {
      WBC_IDLE = 2'h0,
      WBC_FILL = 2'h1,
      WBC_POST = 2'h3,
      WBC_DONE = 2'h2
   } wbc_state_e;
endpackage
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] A = 12'h4a0;
   // expected ready source per select code: sinc4, none, filtered, processed
   localparam logic [3:0] ES [4] = '{4'h1, 4'h0, 4'h2, 4'h4};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] strb = 4'h0;
   logic trig = 1'b0;
   logic wr, rd, rvalid, rdy, wen, act, done, ben, v;
   logic [11:0] addr;
   logic [15:0] wdata, rdata, d, x;
   logic [3:0] waddr, taddr, wexp;
   logic [6:0] mask;
   logic [1:0] src = 2'h0;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 22;
   int n;
   always #2 clk = ~clk;
   wbc_ctrl #(.DEPTH(16)) uut (.core_clk_in(clk), .rst_in(rst),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .sinc4_strobe_in(strb[0]), .filtered_strobe_in(strb[1]),
      .processed_strobe_in(strb[2]), .resample_strobe_in(strb[3]),
      .trigger_in(trig), .sample_ready_strobe_out(rdy),
      .buf_wr_en_out(wen), .buf_wr_addr_out(waddr), .trig_addr_out(taddr),
      .capture_active_out(act), .capture_done_out(done),
      .burst_enable_out(ben), .burst_mask_out(mask));
   wbc_host host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
      .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
   task automatic check(input string nm, input logic [15:0] s,
                        input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [7:0] eb(input logic [3:0] c, input logic nu);
      case (c)
         4'h0: eb = {1'b1, nu, 6'h3f};
         4'h1: eb = 8'h83;
         4'h2: eb = 8'h8c;
         4'h3: eb = 8'hb0;
         4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: eb = 8'h80 | (8'h01 << (c - 8));
         4'he: eb = {1'b1, nu, 6'h00};
         default: eb = 8'h00;
      endcase
   endfunction
   task automatic pulse(input logic [3:0] s, input logic t, input logic ew);
      @(negedge clk);
      strb = s;
      trig = t;
      @(negedge clk);
      strb = 4'h0;
      trig = 1'b0;
      check("ready", 16'(rdy), 16'(|(s & ES[src])));
      check("wr_en", 16'(wen), 16'(ew));
      if (ew) begin
         check("wr_addr", 16'(waddr), 16'(wexp));
         wexp++;
      end
   endtask
   // go is cleared first so every start is a true rising edge
   task automatic start(input logic [15:0] c);
      src = c[9:8];
      host.wr(A, c & 16'hffef);
      host.wr(A, c | 16'h0010);
      repeat (2) @(negedge clk);
      wexp = 4'h0;
   endtask
   initial begin
      #(30000 * 4);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      host.rd(A, d, v);
      check("cfg reset", d, 16'h0000);
      check("rvalid", 16'(v), 16'h0001);
      host.rd(12'h4a1, d, v);
      check("unmapped", d, 16'h0000);
      repeat (12) begin
         x = 16'($random(seed)) & 16'hffef;
         // the host never selects the reserved source code
         if (x[9:8] == 2'h1) x[9] = 1'b1;
         host.wr(A, x);
         host.rd(A, d, v);
         check("cfg readback", d, x & 16'h13ff);
      end
      $display("test registers finished");
      for (int i = 0; i < 32; i++) begin
         host.wr(A, {3'h0, i[4], 8'h00, i[3:0]});
         @(negedge clk);
         x = {8'h00, eb(i[3:0], i[4])};
         check("burst", {8'h00, ben, mask}, x);
      end
      $display("test burst finished");
      for (int s = 0; s < 4; s++) begin
         // the reserved source is never selected, so 11 runs twice
         src = (s == 1) ? 2'h3 : s[1:0];
         host.wr(A, {6'h00, src, 8'h20});
         for (int k = 0; k < 4; k++)
            pulse(4'h1 << k, 1'b0, 1'b0);
      end
      $display("test sources finished");
      start(16'h0020);
      pulse(4'h2, 1'b0, 1'b0);
      repeat (16) pulse(4'h1, 1'b0, 1'b1);
      @(negedge clk);
      check("done once", 16'(done), 16'h0001);
      pulse(4'h1, 1'b0, 1'b0);
      host.wr(A, 16'h0020);
      repeat (2) @(negedge clk);
      check("active off", 16'(act), 16'h0000);
      pulse(4'h1, 1'b0, 1'b0);
      $display("test fill once finished");
      start(16'h0060);
      n = 1 + ($random(seed) & 7);
      repeat (n) pulse(4'h1, 1'b0, 1'b1);
      pulse(4'h0, 1'b1, 1'b0);
      @(negedge clk);
      check("done trig", 16'(done), 16'h0001);
      check("trig addr", 16'(taddr), 16'(wexp - 4'h1));
      pulse(4'h1, 1'b0, 1'b0);
      start(16'h00a0);
      repeat (20) pulse(4'h1, 1'b0, 1'b1);
      pulse(4'h0, 1'b1, 1'b0);
      repeat (8) pulse(4'h1, 1'b0, 1'b1);
      @(negedge clk);
      check("done center", 16'(done), 16'h0001);
      pulse(4'h1, 1'b0, 1'b0);
      start(16'h00e0);
      repeat (5) pulse(4'h1, 1'b0, 1'b1);
      pulse(4'h0, 1'b1, 1'b0);
      @(negedge clk);
      check("mark addr", 16'(taddr), 16'h0004);
      repeat (20) pulse(4'h1, 1'b0, 1'b1);
      check("mark run", {14'h0, act, done}, 16'h0002);
      pulse(4'h1, 1'b1, 1'b1);
      check("mark same", 16'(taddr), 16'(wexp - 4'h1));
      host.wr(A, 16'h00e0);
      pulse(4'h1, 1'b0, 1'b0);
      check("halt", {14'h0, act, done}, 16'h0000);
      $display("test triggers finished");
      start(16'h0300);
      pulse(4'h4, 1'b0, 1'b0);
      repeat (16) pulse(4'h8, 1'b0, 1'b1);
      @(negedge clk);
      check("done resampled", 16'(done), 16'h0001);
      // under source 10 only the filtered strobe may land
      start(16'h0260);
      for (int k = 0; k < 4; k++)
         pulse(4'h1 << k, 1'b0, k == 1);
      start(16'h0220);
      pulse(4'h1, 1'b0, 1'b0);
      pulse(4'h2, 1'b0, 1'b1);
      start(16'h0320);
      pulse(4'h4, 1'b0, 1'b1);
      $display("test capture types finished");
      test_done();
   end
endmodule
`default_nettype wire

// ### tb/wbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module wbc_host (
   input wire logic clk_in,
   input wire logic rvalid_in,
   input wire logic [15:0] rdata_in,
   output logic wr_out,
   output logic rd_out,
   output logic [11:0] addr_out,
   output logic [15:0] wdata_out
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 12'h000;
      wdata_out = 16'h0000;
   end
   // released lines flip so a stale value cannot pass for a held one
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk_in);
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [15:0] d,
                     output logic v);
      @(negedge clk_in);
      rd_out = 1'b1;
      addr_out = a;
      @(negedge clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
      d = rdata_in;
      v = rvalid_in;
   endtask
endmodule
`default_nettype wire
